// [pkg/cbt_map.svh]
// Purpose: register offsets, field positions, reset values and counts
// Assumes: 20 MHz system clock, APB byte addresses, 32-bit words
// Notes: field macros give the low bit index of each field
`ifndef CBT_MAP_SVH
`define CBT_MAP_SVH
`define CBT_OFS_CTRL     12'h000
`define CBT_OFS_TIMING   12'h004
`define CBT_OFS_STATUS   12'h008
`define CBT_OFS_ERRCNT   12'h00C
`define CBT_OFS_IRQ_STAT 12'h010
`define CBT_OFS_IRQ_CLR  12'h014
`define CBT_OFS_IRQ_EN   12'h018
`define CBT_OFS_FRAMES   12'h01C
`define CBT_CTRL_EN      0
`define CBT_CTRL_RATE    1
`define CBT_CTRL_FS_CLR  3
`define CBT_TIM_BRP      0
`define CBT_TIM_TSEG1    8
`define CBT_TIM_TSEG2    12
`define CBT_TIM_SJW      16
`define CBT_RST_BRP      6'h00
`define CBT_RST_RATE     2'h0
`define CBT_RST_TSEG1    4'hE
`define CBT_RST_TSEG2    3'h3
`define CBT_RST_SJW      2'h3
`define CBT_IRQ_BITS     5
`define CBT_FS_DOM_BITS  5'h11
`define CBT_BO_RUN_BITS  4'hB
`define CBT_BO_RUNS      8'h80
`define CBT_TEC_ERR_STEP 9'h008
`define CBT_PASSIVE_LIM  9'h07F
`define CBT_BUSOFF_LIM   9'h0FF
`define CBT_REC_MAX      8'hFF
`define CBT_REC_CAP      8'h7F
`endif

// [pkg/cbt_pkg.sv]
// Purpose: shared types of the CAN bit timing adapter
// Assumes: used together with cbt_map.svh
// Notes: enum order is the status register encoding
package cbt_pkg;
  typedef enum logic [1:0] {CBT_ERR_ACTIVE, CBT_ERR_PASSIVE, CBT_ERR_BUSOFF} cbt_err_t;
  typedef enum logic [1:0] {CBT_SEG_SYNC, CBT_SEG_ONE, CBT_SEG_TWO} cbt_seg_t;
  typedef struct packed {
    logic tx_err;
    logic rx_err;
    logic tx_ok;
    logic rx_ok;
    logic rx_ide;
  } cbt_ev_t;
  typedef struct packed {
    logic [5:0] brp;
    logic [1:0] rate;
    logic [3:0] tseg1;
    logic [2:0] tseg2;
    logic [1:0] resync_jump_limit_alt;
  } cbt_tim_t;
endpackage : cbt_pkg

// [hw/cbt_bit_timing.sv]
// Purpose: quantum prescaler, bit segments, hard sync and resync
// Assumes: fall_i marks a recessive to dominant edge only
// Notes: one resync per bit; sjw already clamped by the writer
`timescale 1ns/1ps
`default_nettype none
module cbt_bit_timing
  import cbt_pkg::*;
(
  // Clock and reset
  input  wire logic     sys_clk_i,
  input  wire logic     rst_i,
  // Configuration and bus edges
  input  wire cbt_tim_t tim_i,
  input  wire logic     run_i,
  input  wire logic     hard_sync_i,
  input  wire logic     fall_i,
  // Bit strobes
  output logic          sample_o,
  output logic          bit_start_o
);
  cbt_seg_t   seg_ff;
  logic [9:0] pre_ff;
  logic [4:0] q_ff;
  logic [4:0] len1_ff;
  logic [3:0] len2_ff;
  logic       synced_ff;

  wire [9:0] tq_last   = (({4'h0, tim_i.brp} + 10'd1) << tim_i.rate) - 10'd1;
  wire       tick      = (pre_ff >= tq_last);
  wire [4:0] len1      = {1'b0, tim_i.tseg1} + 5'd1;
  wire [3:0] len2      = {1'b0, tim_i.tseg2} + 4'd1;
  wire [4:0] resync_jump_limit_alt       = {3'b000, tim_i.resync_jump_limit_alt} + 5'd1;
  wire [4:0] late      = q_ff + 5'd1;
  wire [3:0] early     = len2_ff - q_ff[3:0];
  wire       resync    = fall_i && !synced_ff && !hard_sync_i;
  wire       do_hard   = fall_i && hard_sync_i;
  wire       ext1      = resync && (seg_ff == CBT_SEG_ONE);
  wire       cut2      = resync && (seg_ff == CBT_SEG_TWO) && ({1'b0, early} > resync_jump_limit_alt);
  wire       early_cut = resync && (seg_ff == CBT_SEG_TWO) && ({1'b0, early} <= resync_jump_limit_alt);
  wire       end1      = tick && (seg_ff == CBT_SEG_ONE) && (q_ff == len1_ff - 5'd1) && !ext1;
  wire       end2      = tick && (seg_ff == CBT_SEG_TWO) && (q_ff == {1'b0, len2_ff} - 5'd1);
  wire [4:0] jump      = (late > resync_jump_limit_alt) ? resync_jump_limit_alt : late;

  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      seg_ff      <= CBT_SEG_SYNC;
      pre_ff      <= 10'h000;
      q_ff        <= 5'h00;
      len1_ff     <= 5'h01;
      len2_ff     <= 4'h1;
      synced_ff   <= 1'b0;
      sample_o    <= 1'b0;
      bit_start_o <= 1'b0;
    end else if (!run_i) begin
      seg_ff      <= CBT_SEG_SYNC;
      pre_ff      <= 10'h000;
      q_ff        <= 5'h00;
      synced_ff   <= 1'b0;
      sample_o    <= 1'b0;
      bit_start_o <= 1'b0;
    end else begin
      sample_o    <= end1;
      bit_start_o <= do_hard || early_cut || end2;
      if (do_hard || early_cut) begin
        seg_ff    <= CBT_SEG_ONE;
        pre_ff    <= 10'h000;
        q_ff      <= 5'h00;
        len1_ff   <= len1;
        len2_ff   <= len2;
        synced_ff <= 1'b1;
      end else begin
        pre_ff <= tick ? 10'h000 : pre_ff + 10'd1;
        if (ext1) begin
          len1_ff   <= len1 + jump;
          synced_ff <= 1'b1;
        end else if (cut2) begin
          len2_ff   <= len2_ff - resync_jump_limit_alt[3:0];
          synced_ff <= 1'b1;
        end
        if (tick) begin
          case (seg_ff)
            CBT_SEG_SYNC: begin
              seg_ff    <= CBT_SEG_ONE;
              q_ff      <= 5'h00;
              len1_ff   <= len1;
              len2_ff   <= len2;
              synced_ff <= 1'b0;
            end
            CBT_SEG_ONE: begin
              seg_ff <= end1 ? CBT_SEG_TWO : CBT_SEG_ONE;
              q_ff   <= end1 ? 5'h00 : q_ff + 5'd1;
            end
            CBT_SEG_TWO: begin
              seg_ff <= end2 ? CBT_SEG_SYNC : CBT_SEG_TWO;
              q_ff   <= end2 ? 5'h00 : q_ff + 5'd1;
            end
            default: begin
              seg_ff <= CBT_SEG_SYNC;
              q_ff   <= 5'h00;
            end
          endcase
        end
      end
    end
  end
endmodule : cbt_bit_timing
`default_nettype wire

// [hw/cbt_fault_conf.sv]
// Purpose: transmit and receive error counters and node error state
// Assumes: event inputs are one-cycle pulses from the frame engine
// Notes: recovery needs 128 runs of 11 recessive samples
`timescale 1ns/1ps
`default_nettype none
`include "cbt_map.svh"
module cbt_fault_conf
  import cbt_pkg::*;
(
  // Clock and reset
  input  wire logic    sys_clk_i,
  input  wire logic    rst_i,
  // Events and bus samples
  input  wire cbt_ev_t ev_i,
  input  wire logic    sample_i,
  input  wire logic    rx_i,
  // Counters and state
  output logic [8:0]   tec_o,
  output logic [7:0]   rec_o,
  output cbt_err_t     state_o
);
  logic [3:0] run_ff;
  logic [7:0] occ_ff;
  logic [8:0] nxt_tec;
  logic [7:0] nxt_rec;

  wire busoff    = (state_o == CBT_ERR_BUSOFF);
  wire run_done  = sample_i && rx_i && (run_ff == `CBT_BO_RUN_BITS - 4'd1);
  wire recovered = busoff && run_done && (occ_ff == `CBT_BO_RUNS - 8'd1);

  always_comb begin
    nxt_tec = tec_o;
    nxt_rec = rec_o;
    if (recovered) begin
      nxt_tec = 9'h000;
      nxt_rec = 8'h00;
    end else if (!busoff) begin
      if (ev_i.tx_err)
        nxt_tec = tec_o + `CBT_TEC_ERR_STEP;
      else if (ev_i.tx_ok && tec_o != 9'h000)
        nxt_tec = tec_o - 9'd1;
      if (ev_i.rx_err && rec_o != `CBT_REC_MAX)
        nxt_rec = rec_o + 8'd1;
      else if (ev_i.rx_ok && rec_o > `CBT_REC_CAP)
        nxt_rec = `CBT_REC_CAP;
      else if (ev_i.rx_ok && rec_o != 8'h00)
        nxt_rec = rec_o - 8'd1;
    end
  end

  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      tec_o   <= 9'h000;
      rec_o   <= 8'h00;
      state_o <= CBT_ERR_ACTIVE;
      run_ff  <= 4'h0;
      occ_ff  <= 8'h00;
    end else begin
      tec_o <= nxt_tec;
      rec_o <= nxt_rec;
      if (nxt_tec > `CBT_BUSOFF_LIM)
        state_o <= CBT_ERR_BUSOFF;
      else if (nxt_tec > `CBT_PASSIVE_LIM || {1'b0, nxt_rec} > `CBT_PASSIVE_LIM)
        state_o <= CBT_ERR_PASSIVE;
      else
        state_o <= CBT_ERR_ACTIVE;
      if (!busoff) begin
        run_ff <= 4'h0;
        occ_ff <= 8'h00;
      end else if (sample_i) begin
        run_ff <= (!rx_i || run_done) ? 4'h0 : run_ff + 4'd1;
        occ_ff <= run_done ? occ_ff + 8'd1 : occ_ff;
      end
    end
  end
endmodule : cbt_fault_conf
`default_nettype wire

// [hw/cbt_top.sv]
// Purpose: CAN node bit timing, transceiver adapter and fault confinement
// Assumes: frame engine outside; 1 = recessive on tx_bit_i and the bus
// Notes: APB answers with one wait state; registers at fixed offsets
`timescale 1ns/1ps
`default_nettype none
`include "cbt_map.svh"
module cbt_top
  import cbt_pkg::*;
(
  // Clock and reset
  input  wire logic        sys_clk_i,
  input  wire logic        rst_i,
  // APB slave
  input  wire logic        psel_i,
  input  wire logic        penable_i,
  input  wire logic        pwrite_i,
  input  wire logic [11:0] paddr_i,
  input  wire logic [31:0] pwdata_i,
  output logic      [31:0] prdata_o,
  output logic             pready_o,
  output logic             pslverr_o,
  // Frame engine side
  input  wire logic        tx_bit_i,
  input  wire logic        hard_sync_en_i,
  input  wire cbt_ev_t     ev_i,
  output logic             rx_bit_o,
  output logic             sample_o,
  output logic             bit_start_o,
  // Transceiver pins
  input  wire logic        bus_sense_line_i,
  output logic             transceiver_data_input_o,
  output logic             transceiver_drive_gate_o,
  output logic             listen_gate_n_o,
  // Status and interrupt
  output logic             bus_off_o,
  output logic             err_passive_o,
  output logic             irq_o
);
  // Configuration and state registers
  cbt_tim_t                  tim_ff;
  logic                      en_ff;
  logic                      rx_q_ff;
  logic                      rx_prev_ff;
  logic [4:0]                dom_run_ff;
  logic                      fs_trip_ff;
  logic                      last_ide_ff;
  logic [15:0]               std_cnt_ff;
  logic [15:0]               ext_cnt_ff;
  logic [`CBT_IRQ_BITS-1:0]  irq_stat_ff;
  logic [`CBT_IRQ_BITS-1:0]  irq_en_ff;
  cbt_err_t                  prev_state_ff;

  // Submodule outputs
  logic                      bt_sample;
  logic                      bt_bit_start;
  logic [8:0]                tec;
  logic [7:0]                rec;
  cbt_err_t                  err_state;

  // APB decode
  wire        setup_done = psel_i & penable_i & ~pready_o;
  wire        xfer       = psel_i & penable_i & pready_o;
  wire        wr         = xfer & pwrite_i;
  // Read word latched a cycle early; pready ends it
  wire        rd_cap     = setup_done & ~pwrite_i;
  wire [11:0] word_addr  = {paddr_i[11:2], 2'b00};
  wire        hit_ctrl   = (word_addr == `CBT_OFS_CTRL);
  wire        hit_tim    = (word_addr == `CBT_OFS_TIMING);
  wire        hit_stat   = (word_addr == `CBT_OFS_STATUS);
  wire        hit_err    = (word_addr == `CBT_OFS_ERRCNT);
  wire        hit_irqs   = (word_addr == `CBT_OFS_IRQ_STAT);
  wire        hit_irqc   = (word_addr == `CBT_OFS_IRQ_CLR);
  wire        hit_irqe   = (word_addr == `CBT_OFS_IRQ_EN);
  wire        hit_frm    = (word_addr == `CBT_OFS_FRAMES);
  wire        mapped     = hit_ctrl | hit_tim | hit_stat | hit_err |
                           hit_irqs | hit_irqc | hit_irqe | hit_frm;
  wire        wr_ctrl    = wr & hit_ctrl;
  wire        wr_tim     = wr & hit_tim;
  wire        wr_irqe    = wr & hit_irqe;
  wire        fs_clr     = wr_ctrl & pwdata_i[`CBT_CTRL_FS_CLR];

  wire [1:0]  sjw_req    = pwdata_i[`CBT_TIM_SJW +: 2];
  wire [3:0]  tseg1_req  = pwdata_i[`CBT_TIM_TSEG1 +: 4];
  wire [1:0]  sjw_ok     = ({2'b00, sjw_req} > tseg1_req) ? tseg1_req[1:0] : sjw_req;

  // Error state views
  wire        is_busoff  = (err_state == CBT_ERR_BUSOFF);
  wire        is_passive = (err_state == CBT_ERR_PASSIVE);

  // sense line taken as true level
  wire        bus_fall   = rx_prev_ff & ~rx_q_ff;

  // recessive whenever not allowed to send
  // Forced off here so a stuck engine cannot hold the bus
  wire        tx_block   = ~en_ff | is_busoff | fs_trip_ff;
  wire        tx_rec     = tx_bit_i | tx_block;

  // trip after too many dominant samples
  wire        fs_set     = transceiver_drive_gate_o & bt_sample &
                           (dom_run_ff == `CBT_FS_DOM_BITS - 5'd1);

  // Interrupt sources
  wire        ev_busoff  = is_busoff & (prev_state_ff != CBT_ERR_BUSOFF);
  wire        ev_passive = is_passive & (prev_state_ff == CBT_ERR_ACTIVE);
  wire        ev_recover = (err_state == CBT_ERR_ACTIVE) & (prev_state_ff == CBT_ERR_BUSOFF);
  wire [`CBT_IRQ_BITS-1:0] irq_ev  = {ev_i.rx_ok, fs_set, ev_recover, ev_passive, ev_busoff};
  wire [`CBT_IRQ_BITS-1:0] irq_clr = (wr & hit_irqc) ? pwdata_i[`CBT_IRQ_BITS-1:0]
                                                     : {`CBT_IRQ_BITS{1'b0}};
  // Set wins over a clear in the same cycle
  wire [`CBT_IRQ_BITS-1:0] nxt_irq_stat = (irq_stat_ff & ~irq_clr) | irq_ev;
  // Pin from a flop, so it lags the status by one cycle
  wire        irq_any    = |(irq_stat_ff & irq_en_ff);

  // Readback words
  wire [31:0] rd_ctrl  = {28'h0000000, 1'b0, tim_ff.rate, en_ff};
  wire [31:0] rd_tim   = {14'h0000, tim_ff.resync_jump_limit_alt, 1'b0, tim_ff.tseg2, tim_ff.tseg1,
                          2'b00, tim_ff.brp};
  wire [31:0] rd_stat  = {25'h0000000, rx_q_ff, last_ide_ff, fs_trip_ff,
                          is_passive, is_busoff, err_state};
  // counters read with no side effect
  wire [31:0] rd_err   = {8'h00, rec, 7'h00, tec};
  wire [31:0] rd_irqs  = {{(32-`CBT_IRQ_BITS){1'b0}}, irq_stat_ff};
  wire [31:0] rd_irqe  = {{(32-`CBT_IRQ_BITS){1'b0}}, irq_en_ff};
  wire [31:0] rd_frm   = {ext_cnt_ff, std_cnt_ff};
  wire [31:0] rdata    = hit_ctrl ? rd_ctrl :
                         hit_tim  ? rd_tim  :
                         hit_stat ? rd_stat :
                         hit_err  ? rd_err  :
                         hit_irqs ? rd_irqs :
                         hit_irqe ? rd_irqe :
                         hit_frm  ? rd_frm  : 32'h00000000;

  // quanta and sample point from timing register
  cbt_bit_timing u_bit_timing (
    .sys_clk_i   (sys_clk_i),
    .rst_i       (rst_i),
    .tim_i       (tim_ff),
    .run_i       (en_ff),
    .hard_sync_i (hard_sync_en_i),
    .fall_i      (bus_fall),
    .sample_o    (bt_sample),
    .bit_start_o (bt_bit_start)
  );

  cbt_fault_conf u_fault_conf (
    .sys_clk_i (sys_clk_i),
    .rst_i     (rst_i),
    .ev_i      (ev_i),
    .sample_i  (bt_sample),
    .rx_i      (rx_q_ff),
    .tec_o     (tec),
    .rec_o     (rec),
    .state_o   (err_state)
  );

  // APB answer, one wait state
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      pready_o  <= 1'b0;
      pslverr_o <= 1'b0;
      prdata_o  <= 32'h00000000;
    end else begin
      pready_o  <= setup_done;
      pslverr_o <= setup_done & ~mapped;
      prdata_o  <= rd_cap ? rdata : 32'h00000000;
    end
  end

  // Control and timing registers
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      en_ff        <= 1'b0;
      tim_ff.rate  <= `CBT_RST_RATE;
      tim_ff.brp   <= `CBT_RST_BRP;
      tim_ff.tseg1 <= `CBT_RST_TSEG1;
      tim_ff.tseg2 <= `CBT_RST_TSEG2;
      tim_ff.resync_jump_limit_alt   <= `CBT_RST_SJW;
    end else begin
      // rate select: 1M, 500k, 250k, 125k
      if (wr_ctrl) begin
        en_ff       <= pwdata_i[`CBT_CTRL_EN];
        tim_ff.rate <= pwdata_i[`CBT_CTRL_RATE +: 2];
      end
      if (wr_tim) begin
        tim_ff.brp   <= pwdata_i[`CBT_TIM_BRP +: 6];
        tim_ff.tseg1 <= tseg1_req;
        tim_ff.tseg2 <= pwdata_i[`CBT_TIM_TSEG2 +: 3];
        tim_ff.resync_jump_limit_alt   <= sjw_ok;
      end
    end
  end

  // Bus sensing and engine strobes
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      rx_q_ff     <= 1'b1;
      rx_prev_ff  <= 1'b1;
      rx_bit_o    <= 1'b1;
      sample_o    <= 1'b0;
      bit_start_o <= 1'b0;
    end else begin
      rx_q_ff     <= bus_sense_line_i;
      rx_prev_ff  <= rx_q_ff;
      rx_bit_o    <= bt_sample ? rx_q_ff : rx_bit_o;
      sample_o    <= bt_sample;
      bit_start_o <= bt_bit_start;
    end
  end

  // Transceiver drive and fail-safe
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      transceiver_data_input_o <= 1'b0;
      transceiver_drive_gate_o <= 1'b0;
      listen_gate_n_o          <= 1'b0;
      dom_run_ff               <= 5'h00;
      fs_trip_ff               <= 1'b0;
    end else begin
      // both pins from inverted transmit bit
      transceiver_data_input_o <= ~tx_rec;
      transceiver_drive_gate_o <= ~tx_rec;
      listen_gate_n_o          <= 1'b0;
      if (!transceiver_drive_gate_o)
        dom_run_ff <= 5'h00;
      else if (bt_sample && !fs_set)
        dom_run_ff <= dom_run_ff + 5'd1;
      // Trip holds until software clears; a new trip wins
      fs_trip_ff <= fs_set | (fs_trip_ff & ~fs_clr);
    end
  end

  // Frame statistics
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      last_ide_ff <= 1'b0;
      std_cnt_ff  <= 16'h0000;
      ext_cnt_ff  <= 16'h0000;
    end else if (ev_i.rx_ok) begin
      last_ide_ff <= ev_i.rx_ide;
      std_cnt_ff  <= ev_i.rx_ide ? std_cnt_ff : std_cnt_ff + 16'd1;
      ext_cnt_ff  <= ev_i.rx_ide ? ext_cnt_ff + 16'd1 : ext_cnt_ff;
    end
  end

  // Interrupts and state outputs
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      irq_stat_ff   <= {`CBT_IRQ_BITS{1'b0}};
      irq_en_ff     <= {`CBT_IRQ_BITS{1'b0}};
      prev_state_ff <= CBT_ERR_ACTIVE;
      irq_o         <= 1'b0;
      bus_off_o     <= 1'b0;
      err_passive_o <= 1'b0;
    end else begin
      irq_stat_ff   <= nxt_irq_stat;
      irq_en_ff     <= wr_irqe ? pwdata_i[`CBT_IRQ_BITS-1:0] : irq_en_ff;
      prev_state_ff <= err_state;
      irq_o         <= irq_any;
      bus_off_o     <= is_busoff;
      err_passive_o <= is_passive;
    end
  end
endmodule : cbt_top
`default_nettype wire

// [test/cbt_top_monitor.sv]
// Purpose: port-level checks on the adapter top
// Assumes: one clock domain, asynchronous active-high reset
// Notes: bound into cbt_top below
`timescale 1ns/1ps
`default_nettype none
module cbt_mon
(
  // Clock and reset
  input  wire logic sys_clk_i,
  input  wire logic rst_i,
  // APB
  input  wire logic psel_i,
  input  wire logic penable_i,
  input  wire logic pready_o,
  // Link
  input  wire logic tx_bit_i,
  input  wire logic bus_sense_line_i,
  input  wire logic rx_bit_o,
  input  wire logic sample_o,
  input  wire logic transceiver_data_input_o,
  input  wire logic transceiver_drive_gate_o,
  input  wire logic listen_gate_n_o,
  // Status
  input  wire logic bus_off_o,
  input  wire logic err_passive_o
);
  logic       prev_ff;
  logic       drv_ff;
  logic [2:0] stab_ff;
  logic [4:0] dom_ff;
  logic [2:0] nxt_stab;
  logic [4:0] nxt_dom;
  // Counts saturate so a long run never wraps
  assign nxt_stab = (bus_sense_line_i != prev_ff) ? 3'h0 :
                    (stab_ff == 3'h7) ? 3'h7 : stab_ff + 3'h1;
  // Pin strobe lags the internal one; pair it with last cycle's drive
  assign nxt_dom  = !drv_ff ? 5'h00 :
                    (sample_o && dom_ff != 5'h1F) ? dom_ff + 5'h01 : dom_ff;
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      {prev_ff, drv_ff, stab_ff, dom_ff} <= {1'b1, 1'b0, 3'h0, 5'h00};
    end else begin
      {prev_ff, drv_ff, stab_ff, dom_ff} <= {bus_sense_line_i, transceiver_drive_gate_o,
                                             nxt_stab, nxt_dom};
    end
  end
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (rst_i);
  AST_LISTEN: assert property (listen_gate_n_o == 1'b0)
    else $error("receiver not enabled");
  AST_GATE_EQ: assert property (transceiver_data_input_o == transceiver_drive_gate_o)
    else $error("data and drive gate differ");
  AST_REC_OFF: assert property (tx_bit_i |=> !transceiver_drive_gate_o)
    else $error("driver on for recessive bit");
  AST_RX_LEVEL: assert property (sample_o && stab_ff == 3'h7 |-> rx_bit_o == bus_sense_line_i)
    else $error("sampled level differs from bus");
  AST_RX_HOLD: assert property ($changed(rx_bit_o) |-> sample_o)
    else $error("receive bit moved off sample point");
  AST_FAILSAFE: assert property (dom_ff <= 5'h11)
    else $error("dominant drive outlived trip count");
  AST_BUSOFF_DRV: assert property (bus_off_o ##1 bus_off_o |-> !transceiver_drive_gate_o)
    else $error("driver on while bus-off");
  AST_APB_WAIT: assert property (psel_i && $rose(penable_i) |=> pready_o)
    else $error("ready not after one wait state");
  cover property ($rose(bus_off_o));
  cover property ($rose(err_passive_o));
  cover property (sample_o && !rx_bit_o);
endmodule : cbt_mon
bind cbt_top cbt_mon i_cbt_mon (
  .sys_clk_i, .rst_i, .psel_i, .penable_i, .pready_o, .tx_bit_i, .bus_sense_line_i,
  .rx_bit_o, .sample_o, .transceiver_data_input_o, .transceiver_drive_gate_o,
  .listen_gate_n_o, .bus_off_o, .err_passive_o
);
`default_nettype wire

// [test/cbt_bus_model.sv]
// Purpose: transceiver and shared bus seen from the node pins
// Assumes: termination pulls the bus recessive when undriven
// Notes: a disabled receiver output toggles, never holds a level
`timescale 1ns/1ps
`default_nettype none
module cbt_bus_model
(
  // Clock
  input  wire logic sys_clk_i,
  // Node pins and other nodes
  input  wire logic data_input_i,
  input  wire logic drive_gate_i,
  input  wire logic listen_gate_n_i,
  input  wire logic ext_dom_i,
  // Receiver output
  output logic      bus_sense_line_o
);
  logic tog_ff = 1'b0;
  logic bus_lvl;
  assign bus_lvl = !((drive_gate_i && data_input_i) || ext_dom_i);
  always_ff @(posedge sys_clk_i) tog_ff <= !tog_ff;
  assign bus_sense_line_o = listen_gate_n_i ? tog_ff : bus_lvl;
endmodule : cbt_bus_model
`default_nettype wire

// [test/tb.sv]
// Purpose: self-checking bench for cbt_top
// Assumes: 20 MHz clock, APB master waits for ready
// Notes: bus-off recovery dominates the run time
`timescale 1ns/1ps
`default_nettype none
`include "cbt_map.svh"
module tb
  import cbt_pkg::*;
;
  typedef struct packed {
    logic [11:0] a;
    logic [31:0] d;
    logic        e;
  } cbt_row_t;
  cbt_row_t rows [9] = '{
    '{`CBT_OFS_CTRL, 32'h0, 1'b0}, '{`CBT_OFS_TIMING, 32'h00033E00, 1'b0},
    '{`CBT_OFS_STATUS, 32'h40, 1'b0}, '{`CBT_OFS_ERRCNT, 32'h0, 1'b0},
    '{`CBT_OFS_IRQ_STAT, 32'h0, 1'b0}, '{`CBT_OFS_IRQ_CLR, 32'h0, 1'b0},
    '{`CBT_OFS_IRQ_EN, 32'h0, 1'b0}, '{`CBT_OFS_FRAMES, 32'h0, 1'b0},
    '{12'h020, 32'h0, 1'b1}};
  logic        clk = 1'b0;
  logic        rst, psel, penable, pwrite, pready, pslverr, tx, hs, ext;
  logic        rx, smp, bs, sense, di, dg, lgn, boff, epas, irq, e, h;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, q;
  cbt_ev_t     ev;
  int          miscompares = 0;
  int          cmp_count = 0;
  int          n;
  always #25 clk = ~clk;
  cbt_top i_cbt_top (
    .sys_clk_i(clk), .rst_i(rst), .psel_i(psel), .penable_i(penable), .pwrite_i(pwrite),
    .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready),
    .pslverr_o(pslverr), .tx_bit_i(tx), .hard_sync_en_i(hs), .ev_i(ev), .rx_bit_o(rx),
    .sample_o(smp), .bit_start_o(bs), .bus_sense_line_i(sense),
    .transceiver_data_input_o(di), .transceiver_drive_gate_o(dg), .listen_gate_n_o(lgn),
    .bus_off_o(boff), .err_passive_o(epas), .irq_o(irq));
  cbt_bus_model i_cbt_bus_model (
    .sys_clk_i(clk), .data_input_i(di), .drive_gate_i(dg), .listen_gate_n_i(lgn),
    .ext_dom_i(ext), .bus_sense_line_o(sense));
  task automatic chk32(input logic [31:0] g, input logic [31:0] x);
    cmp_count++;
    if (g !== x) begin
      miscompares++;
      $display("ERROR t=%0t got=%h exp=%h", $time, g, x);
    end
  endtask : chk32
  task automatic chk1(input logic g, input logic x);
    cmp_count++;
    if (g !== x) begin
      miscompares++;
      $display("ERROR t=%0t got=%h exp=%h", $time, g, x);
    end
  endtask : chk1
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int k;
    k = 0;
    @(posedge clk);
    {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
      k++;
    end while (pready !== 1'b1 && k < 50);
    if (k >= 50) miscompares++;
    q = prdata;
    e = pslverr;
    {psel, penable} <= 2'b00;
  endtask : apb
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask : wr
  task automatic rdc(input logic [11:0] a, input logic [31:0] x);
    apb(1'b0, a, 32'h0);
    chk32(q, x);
  endtask : rdc
  task automatic pulse(input cbt_ev_t v, input int k);
    repeat (k) begin
      @(posedge clk);
      ev <= v;
      @(posedge clk);
      ev <= '0;
    end
    repeat (3) @(posedge clk);
  endtask : pulse
  task automatic per(output int p);
    int k;
    k = 0;
    while (smp !== 1'b1 && k < 400) begin
      @(posedge clk);
      k++;
    end
    p = 0;
    do begin
      @(posedge clk);
      p++;
    end while (smp !== 1'b1 && p < 400);
  endtask : per
  task automatic seen(input int k);
    h = 1'b0;
    repeat (k) begin
      @(posedge clk);
      if (bs === 1'b1) h = 1'b1;
    end
  endtask : seen
  task automatic final_report();
    $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : final_report
  initial begin
    #4000000;
    miscompares++;
    final_report();
  end
  initial begin
    {rst, psel, penable, pwrite, hs, ext, tx} = 7'h41;
    {paddr, pwdata, ev} = '0;
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    chk1(rx, 1'b1);
    chk1(dg, 1'b0);
    chk1(lgn, 1'b0);
    foreach (rows[i]) begin
      apb(1'b0, rows[i].a, 32'h0);
      chk32(q, rows[i].d);
      chk1(e, rows[i].e);
    end
    wr(`CBT_OFS_TIMING, 32'h00033100);
    rdc(`CBT_OFS_TIMING, 32'h00013100);
    wr(`CBT_OFS_TIMING, 32'h00033E00);
    for (int r = 3; r >= 0; r--) begin
      wr(`CBT_OFS_CTRL, 32'h1 | 32'(r << 1));
      per(n);
      per(n);
      chk32(32'(n), 32'(20 << r));
    end
    hs <= 1'b1;
    per(n);
    repeat (8) @(posedge clk);
    ext <= 1'b1;
    seen(6);
    chk1(h, 1'b1);
    repeat (25) @(posedge clk);
    chk1(rx, 1'b0);
    per(n);
    repeat (8) @(posedge clk);
    ext <= 1'b0;
    seen(6);
    chk1(h, 1'b0);
    repeat (25) @(posedge clk);
    chk1(rx, 1'b1);
    hs <= 1'b0;
    tx <= 1'b0;
    repeat (2) @(posedge clk);
    chk1(di, 1'b1);
    chk1(dg, 1'b1);
    tx <= 1'b1;
    repeat (2) @(posedge clk);
    chk1(dg, 1'b0);
    tx <= 1'b0;
    repeat (400) @(posedge clk);
    chk1(dg, 1'b0);
    rdc(`CBT_OFS_STATUS, 32'h50);
    wr(`CBT_OFS_IRQ_EN, 32'h8);
    repeat (3) @(posedge clk);
    chk1(irq, 1'b1);
    wr(`CBT_OFS_IRQ_EN, 32'h0);
    repeat (3) @(posedge clk);
    chk1(irq, 1'b0);
    wr(`CBT_OFS_IRQ_CLR, 32'h8);
    rdc(`CBT_OFS_IRQ_STAT, 32'h0);
    tx <= 1'b1;
    wr(`CBT_OFS_CTRL, 32'h9);
    rdc(`CBT_OFS_STATUS, 32'h40);
    pulse(5'h02, 1);
    pulse(5'h03, 1);
    rdc(`CBT_OFS_FRAMES, 32'h00010001);
    rdc(`CBT_OFS_STATUS, 32'h60);
    pulse(5'h08, 130);
    chk1(epas, 1'b1);
    rdc(`CBT_OFS_ERRCNT, 32'h00820000);
    rdc(`CBT_OFS_ERRCNT, 32'h00820000);
    pulse(5'h02, 1);
    rdc(`CBT_OFS_ERRCNT, 32'h007F0000);
    chk1(epas, 1'b0);
    pulse(5'h10, 15);
    chk1(epas, 1'b0);
    pulse(5'h10, 1);
    chk1(epas, 1'b1);
    pulse(5'h04, 1);
    chk1(epas, 1'b0);
    pulse(5'h10, 16);
    chk1(boff, 1'b0);
    pulse(5'h10, 1);
    chk1(boff, 1'b1);
    rdc(`CBT_OFS_ERRCNT, 32'h007F0107);
    n = 0;
    while (boff !== 1'b0 && n < 40000) begin
      @(posedge clk);
      n++;
    end
    chk1(boff, 1'b0);
    rdc(`CBT_OFS_ERRCNT, 32'h0);
    rdc(`CBT_OFS_IRQ_STAT, 32'h17);
    final_report();
  end
endmodule : tb
`default_nettype wire
